// ---- common/ert_pkg.sv ----
package ert_pkg;

    // ------------------------------------------------------------------
    // Bus geometry.
    // ------------------------------------------------------------------
    localparam int PADDR_W = 20;
    localparam int PDATA_W = 32;

    // ------------------------------------------------------------------
    // Register indices, and their word-aligned byte addresses.
    // ------------------------------------------------------------------
    localparam logic [17:0] IDX_DIV    = 18'h04240;
    localparam logic [17:0] IDX_RELOAD = 18'h04242;
    localparam logic [17:0] IDX_COUNT  = 18'h04244;
    localparam logic [17:0] IDX_CTRL   = 18'h04246;
    localparam logic [17:0] IDX_INT    = 18'h04248;

    localparam logic [19:0] ADDR_DIV    = {IDX_DIV, 2'b00};
    localparam logic [19:0] ADDR_RELOAD = {IDX_RELOAD, 2'b00};
    localparam logic [19:0] ADDR_COUNT  = {IDX_COUNT, 2'b00};
    localparam logic [19:0] ADDR_CTRL   = {IDX_CTRL, 2'b00};
    localparam logic [19:0] ADDR_INT    = {IDX_INT, 2'b00};

    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int DIV_W           = 4;
    localparam int CNT_W           = 8;
    localparam int PRE_W           = 14;
    localparam int CTRL_RUN_BIT    = 0;
    localparam int CTRL_RST_BIT    = 1;
    localparam int CTRL_ONESHOT_BIT = 4;
    localparam int INT_FLAG_BIT    = 0;
    localparam int INT_IE_BIT      = 8;

    // ------------------------------------------------------------------
    // Reset values and codes.
    // ------------------------------------------------------------------
    localparam logic [3:0] DIV_RST      = 4'h0;
    localparam logic [3:0] DIV_RESERVED = 4'hf;
    localparam logic [7:0] RELOAD_RST   = 8'h00;
    localparam logic [7:0] COUNT_RST    = 8'hff;

endpackage : ert_pkg

// ---- common/ert_cnt_if.sv ----
`timescale 1ns/1ps
// Signals shared by the register file, the prescaler and the counter core.
interface ert_cnt_if;
    logic       run;       // Counting enabled.
    logic       clear;     // One-cycle counter reset strobe.
    logic [3:0] div_sel;   // Prescaler ratio code.
    logic       tick;      // One-cycle count enable from the prescaler.
    logic [7:0] reload;    // Reload value.
    logic [7:0] count;     // Current count.
    logic       underflow; // Tick while the count stands at zero.

    modport ctl  (output run, clear, div_sel, reload,
                  input  count, underflow, tick);
    modport pre  (input run, clear, div_sel, output tick);
    modport core (input run, clear, tick, reload,
                  output count, underflow);
endinterface : ert_cnt_if

// ---- verilog/ert_prescaler.sv ----
`timescale 1ns/1ps
module ert_prescaler (
    input  wire logic mclk,   // System clock.
    input  wire logic rst_b,  // Asynchronous reset, active low.
    ert_cnt_if.pre    cif     // Run, clear and ratio in, tick out.
);

    logic [13:0] div_q;
    logic [14:0] span;
    logic [13:0] mask;

    // ------------------------------------------------------------------
    // Divider chain.
    // ------------------------------------------------------------------
    // Restarting on stop or clear gives a full first period after start.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            div_q <= 14'h0000;
        end else if (!cif.run || cif.clear) begin
            div_q <= 14'h0000;
        end else begin
            div_q <= div_q + 14'h0001;
        end
    end

    // Ratio code n ticks once every 2**n cycles; the last code never ticks.
    assign span = (15'h0001 << cif.div_sel) - 15'h0001;
    assign mask = span[13:0];
    assign cif.tick = cif.run && !cif.clear
                      && (cif.div_sel != ert_pkg::DIV_RESERVED)
                      && ((div_q & mask) == mask);

    a_tick_reserved: assert property (
        @(posedge mclk) disable iff (!rst_b)
        cif.div_sel == ert_pkg::DIV_RESERVED |-> !cif.tick)
        else $error("Tick seen with reserved ratio code.");

    a_tick_direct: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (cif.div_sel == 4'h0 && cif.run && !cif.clear) |-> cif.tick)
        else $error("Ratio 1/1 missed a tick.");

    a_tick_half: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (cif.tick && cif.div_sel == 4'h1) ##1
        (cif.div_sel == 4'h1 && cif.run && !cif.clear) |-> !cif.tick)
        else $error("Ratio 1/2 ticked twice in a row.");

endmodule : ert_prescaler

// ---- verilog/ert_counter.sv ----
`timescale 1ns/1ps
module ert_counter (
    input  wire logic mclk,   // System clock.
    input  wire logic rst_b,  // Asynchronous reset, active low.
    ert_cnt_if.core   cif     // Controls in, count and underflow out.
);

    logic [7:0] count_q;

    // ------------------------------------------------------------------
    // Down counter.
    // ------------------------------------------------------------------
    assign cif.underflow = cif.run && cif.tick && !cif.clear
                           && (count_q == 8'h00);
    assign cif.count = count_q;

    // A reset strobe wins over a tick in the same cycle.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= ert_pkg::COUNT_RST;
        end else if (cif.clear) begin
            count_q <= cif.reload;
        end else if (cif.underflow) begin
            count_q <= cif.reload;
        end else if (cif.run && cif.tick) begin
            count_q <= count_q - 8'h01;
        end
    end

    a_count_dec: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (cif.run && cif.tick && !cif.clear && count_q != 8'h00)
        |=> count_q == $past(count_q) - 8'h01)
        else $error("Count did not step down on a tick.");

    a_count_reload: assert property (
        @(posedge mclk) disable iff (!rst_b)
        cif.underflow |=> count_q == $past(cif.reload))
        else $error("Underflow did not reload the count.");

    a_count_hold: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (!cif.run && !cif.clear) |=> $stable(count_q))
        else $error("Count moved while stopped.");

    a_reset_strobe: assert property (
        @(posedge mclk) disable iff (!rst_b)
        cif.clear |=> count_q == $past(cif.reload))
        else $error("Reset strobe did not load the count.");

endmodule : ert_counter

// ---- verilog/ert_timer.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Prescaler divides clock by 2**code for codes 0..14; code 15 reserved.
// - Eight-bit reload value, read and write, zero after reset.
// - Current count readable only, all ones after reset.
// - Control bit 4 picks one-shot when 1, repeat when 0.
// - Writing 1 to control bit 1 resets the counter; 0 ignored.
// - Control bit 0 runs the counter when 1, stops it when 0.
// - Interrupt enable at bit 8 gates the request; zero after reset.
// - Flag at bit 0 set by underflow, cleared only by writing 1.
module ert_timer (
    input  wire logic        mclk,    // System clock, 25 MHz.
    input  wire logic        rst_b,   // Asynchronous reset, active low.
    input  wire logic        psel,    // APB select.
    input  wire logic        penable, // APB access phase.
    input  wire logic        pwrite,  // APB direction, 1 is write.
    input  wire logic [19:0] paddr,   // APB byte address.
    input  wire logic [31:0] pwdata,  // APB write data.
    output logic      [31:0] prdata,  // APB read data.
    output logic             pready,  // APB transfer done.
    output logic             pslverr, // APB error, unmapped address.
    output logic             irq      // Interrupt request, active high.
);

    // ------------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------------
    ert_cnt_if cif ();

    logic [3:0]  div_q;
    logic [7:0]  reload_q;
    logic        run_q;
    logic        run_d;
    logic        one_shot_q;
    logic        ie_q;
    logic        flag_q;
    logic        flag_d;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        irq_q;

    logic        hit_div;
    logic        hit_reload;
    logic        hit_count;
    logic        hit_ctrl;
    logic        hit_int;
    logic        hit_any;
    logic        access;
    logic        wr;
    logic        wr_ctrl;
    logic        flag_w1c;
    logic [31:0] rd_word;

    // ------------------------------------------------------------------
    // Sub-blocks.
    // ------------------------------------------------------------------
    ert_prescaler u_pre (
        .mclk  (mclk),
        .rst_b (rst_b),
        .cif   (cif)
    );

    ert_counter u_core (
        .mclk  (mclk),
        .rst_b (rst_b),
        .cif   (cif)
    );

    assign cif.run     = run_q;
    assign cif.div_sel = div_q;
    assign cif.reload  = reload_q;

    // ------------------------------------------------------------------
    // APB decode.
    // ------------------------------------------------------------------
    // Every access takes one wait state, so pready always comes from a
    // flip-flop and a write lands on the edge that samples it high.
    assign access = psel && penable;
    assign wr     = access && pwrite && pready_q;

    always_comb begin
        hit_div    = 1'b0;
        hit_reload = 1'b0;
        hit_count  = 1'b0;
        hit_ctrl   = 1'b0;
        hit_int    = 1'b0;
        if (paddr == ert_pkg::ADDR_DIV) begin
            hit_div = 1'b1;
        end else if (paddr == ert_pkg::ADDR_RELOAD) begin
            hit_reload = 1'b1;
        end else if (paddr == ert_pkg::ADDR_COUNT) begin
            hit_count = 1'b1;
        end else if (paddr == ert_pkg::ADDR_CTRL) begin
            hit_ctrl = 1'b1;
        end else if (paddr == ert_pkg::ADDR_INT) begin
            hit_int = 1'b1;
        end
    end

    assign hit_any  = hit_div || hit_reload || hit_count
                      || hit_ctrl || hit_int;
    assign wr_ctrl  = wr && hit_ctrl;
    assign flag_w1c = wr && hit_int && pwdata[ert_pkg::INT_FLAG_BIT];

    // The strobe bit is never stored, so it always reads back as zero.
    assign cif.clear = wr_ctrl && pwdata[ert_pkg::CTRL_RST_BIT];

    // ------------------------------------------------------------------
    // Read mux; reserved bits are zero.
    // ------------------------------------------------------------------
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit_div) begin
            rd_word[3:0] = div_q;
        end else if (hit_reload) begin
            rd_word[7:0] = reload_q;
        end else if (hit_count) begin
            rd_word[7:0] = cif.count;
        end else if (hit_ctrl) begin
            rd_word[ert_pkg::CTRL_ONESHOT_BIT] = one_shot_q;
            rd_word[ert_pkg::CTRL_RUN_BIT]     = run_q;
        end else if (hit_int) begin
            rd_word[ert_pkg::INT_IE_BIT]   = ie_q;
            rd_word[ert_pkg::INT_FLAG_BIT] = flag_q;
        end
    end

    // Answer: data, ready and error rise together one cycle into access.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (access && !pready_q) begin
            prdata_q  <= pwrite ? 32'h0000_0000 : rd_word;
            pready_q  <= 1'b1;
            pslverr_q <= !hit_any;
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers.
    // ------------------------------------------------------------------
    // Ratio select; a change takes hold at once, without restarting the divider chain.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            div_q <= ert_pkg::DIV_RST;
        end else if (wr && hit_div) begin
            div_q <= pwdata[3:0];
        end
    end

    // Reload value.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            reload_q <= ert_pkg::RELOAD_RST;
        end else if (wr && hit_reload) begin
            reload_q <= pwdata[7:0];
        end
    end

    // Mode select.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            one_shot_q <= 1'b0;
        end else if (wr_ctrl) begin
            one_shot_q <= pwdata[ert_pkg::CTRL_ONESHOT_BIT];
        end
    end

    // Run bit: a software write wins over a one-shot stop in the same
    // cycle, so a restart issued at underflow is never lost.
    always_comb begin
        run_d = run_q;
        if (wr_ctrl) begin
            run_d = pwdata[ert_pkg::CTRL_RUN_BIT];
        end else if (cif.underflow && one_shot_q) begin
            run_d = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            run_q <= 1'b0;
        end else begin
            run_q <= run_d;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt.
    // ------------------------------------------------------------------
    // Set wins over a write-one clear arriving in the same cycle.
    assign flag_d = (flag_q && !flag_w1c) || cif.underflow;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ie_q <= 1'b0;
        end else if (wr && hit_int) begin
            ie_q <= pwdata[ert_pkg::INT_IE_BIT];
        end
    end

    // Registered from next-state values so the pin tracks flag and enable
    // in the same cycle without a combinational output path.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= flag_d && (wr && hit_int ?
                     pwdata[ert_pkg::INT_IE_BIT] : ie_q);
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign irq     = irq_q;

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    a_irq_level: assert property (
        @(posedge mclk) disable iff (!rst_b)
        irq_q == (flag_q && ie_q))
        else $error("Interrupt pin disagrees with flag and enable.");

    a_irq_gated: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (wr && hit_int && !pwdata[ert_pkg::INT_IE_BIT]) |=> !irq_q)
        else $error("Request seen with enable written off.");

    a_flag_set: assert property (
        @(posedge mclk) disable iff (!rst_b)
        cif.underflow |=> flag_q)
        else $error("Underflow did not set the flag.");

    a_flag_hold: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (flag_q && !flag_w1c) |=> flag_q)
        else $error("Flag dropped without a write of one.");

    a_flag_clear: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (flag_w1c && !cif.underflow) |=> !flag_q)
        else $error("Write of one did not clear the flag.");

    a_oneshot_stop: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (cif.underflow && one_shot_q && !wr_ctrl)
        |=> !run_q ##1 (!run_q || $past(wr_ctrl)))
        else $error("One-shot mode kept running after underflow.");

    a_repeat_run: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (cif.underflow && !one_shot_q && !wr_ctrl) |=> run_q)
        else $error("Repeat mode stopped at underflow.");

    a_reload_write: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (wr && hit_reload) |=> reload_q == $past(pwdata[7:0]))
        else $error("Reload write not stored.");

    a_ctrl_read: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (access && !pready_q && !pwrite && hit_ctrl)
        |=> prdata_q[31:5] == 27'h0 && prdata_q[3:1] == 3'h0)
        else $error("Reserved control bits read nonzero.");

    a_bus_answer: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (access && !pready_q) |=> pready_q ##1 !pready_q)
        else $error("Bus answer not exactly one wait state.");

    // Each configuration write must be visible on the very next cycle.
    a_div_write: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (wr && hit_div) |=> div_q == $past(pwdata[3:0]))
        else $error("Ratio write not stored.");

    a_run_write: assert property (
        @(posedge mclk) disable iff (!rst_b)
        wr_ctrl |=> run_q == $past(pwdata[ert_pkg::CTRL_RUN_BIT]))
        else $error("Run bit write not stored.");

    a_mode_write: assert property (
        @(posedge mclk) disable iff (!rst_b)
        wr_ctrl |=> one_shot_q == $past(pwdata[ert_pkg::CTRL_ONESHOT_BIT]))
        else $error("Mode bit write not stored.");

    a_ie_write: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (wr && hit_int) |=> ie_q == $past(pwdata[ert_pkg::INT_IE_BIT]))
        else $error("Interrupt enable write not stored.");

    a_bus_error: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (access && !pready_q && !hit_any) |=> pslverr_q)
        else $error("Unmapped address gave no error.");

endmodule : ert_timer

// ---- tb/ert_timer_test.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR t=%0t got %h expected %h", $time, (g), (e)); end end

module ert_timer_test;

    logic        mclk;        // Bench clock.
    logic        rst_b;       // Bench reset, active low.
    logic        psel;        // APB select.
    logic        penable;     // APB access phase.
    logic        pwrite;      // APB direction.
    logic [19:0] paddr;       // APB address.
    logic [31:0] pwdata;      // APB write data.
    logic [31:0] prdata;      // APB read data.
    logic        pready;      // APB done.
    logic        pslverr;     // APB error.
    logic        irq;         // Interrupt request.
    int          mismatches;  // Failed comparisons.
    int          cmp_count;   // All comparisons.

    ert_timer dut (
        .mclk    (mclk),
        .rst_b   (rst_b),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .irq     (irq)
    );

    // ------------------------------------------------------------------
    // Bus tasks.
    // ------------------------------------------------------------------

    // One APB transfer; the request is held until pready is seen high,
    // then released with one idle cycle so back-to-back calls never
    // assign the same signal twice in one time step.
    task automatic apb(input logic wr, input logic [19:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) begin
            mismatches++;
            $display("ERROR t=%0t no bus answer", $time);
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb

    task automatic reg_wr(input logic [19:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : reg_wr

    task automatic reg_rd(input logic [19:0] a, output logic [31:0] d);
        logic e;
        apb(1'b0, a, 32'h0000_0000, d, e);
    endtask : reg_rd

    // Bounded wait for the request; n is the cycles spent waiting.
    task automatic wait_irq(output int n);
        n = 0;
        while (irq !== 1'b1 && n < 40000) begin
            @(posedge mclk);
            n++;
        end
    endtask : wait_irq

    // ------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------

    task automatic t_reset_access;
        logic [31:0] d;
        logic        e;
        `CHK(irq, 1'b0)
        reg_rd(ert_pkg::ADDR_DIV, d);
        `CHK(d, 32'h0000_0000)
        reg_rd(ert_pkg::ADDR_RELOAD, d);
        `CHK(d, 32'h0000_0000)
        reg_rd(ert_pkg::ADDR_COUNT, d);
        `CHK(d, 32'h0000_00ff)
        reg_rd(ert_pkg::ADDR_CTRL, d);
        `CHK(d, 32'h0000_0000)
        reg_rd(ert_pkg::ADDR_INT, d);
        `CHK(d, 32'h0000_0000)
        reg_wr(ert_pkg::ADDR_DIV, 32'hffff_fff3);
        reg_rd(ert_pkg::ADDR_DIV, d);
        `CHK(d, 32'h0000_0003)
        reg_wr(ert_pkg::ADDR_RELOAD, 32'hffff_ff5a);
        reg_rd(ert_pkg::ADDR_RELOAD, d);
        `CHK(d, 32'h0000_005a)
        reg_wr(ert_pkg::ADDR_COUNT, 32'h0000_0012);
        reg_rd(ert_pkg::ADDR_COUNT, d);
        `CHK(d, 32'h0000_00ff)
        reg_wr(ert_pkg::ADDR_CTRL, 32'h0000_0010);
        reg_rd(ert_pkg::ADDR_CTRL, d);
        `CHK(d, 32'h0000_0010)
        reg_wr(ert_pkg::ADDR_CTRL, 32'h0000_0000);
        apb(1'b0, 20'h00004, 32'h0000_0000, d, e);
        `CHK(e, 1'b1)
        `CHK(d, 32'h0000_0000)
    endtask : t_reset_access

    // Reload 0 underflows on the first tick, so the wait measures 2**k.
    task automatic t_divide;
        int n;
        reg_wr(ert_pkg::ADDR_RELOAD, 32'h0000_0000);
        for (int k = 0; k < 15; k++) begin
            reg_wr(ert_pkg::ADDR_DIV, 32'(k));
            reg_wr(ert_pkg::ADDR_CTRL, 32'h0000_0002);
            reg_wr(ert_pkg::ADDR_INT, 32'h0000_0101);
            reg_wr(ert_pkg::ADDR_CTRL, 32'h0000_0001);
            wait_irq(n);
            `CHK((n >= (1 << k) - 3) && (n <= (1 << k) + 2), 1'b1)
            reg_wr(ert_pkg::ADDR_CTRL, 32'h0000_0000);
        end
    endtask : t_divide

    task automatic t_modes;
        int          n;
        logic [31:0] d;
        reg_wr(ert_pkg::ADDR_DIV, 32'h0000_0000);
        reg_wr(ert_pkg::ADDR_RELOAD, 32'h0000_0003);
        reg_wr(ert_pkg::ADDR_CTRL, 32'h0000_0002);
        reg_wr(ert_pkg::ADDR_INT, 32'h0000_0101);
        reg_wr(ert_pkg::ADDR_CTRL, 32'h0000_0001);
        wait_irq(n);
        reg_rd(ert_pkg::ADDR_CTRL, d);
        `CHK(d, 32'h0000_0001)
        reg_wr(ert_pkg::ADDR_CTRL, 32'h0000_0002);
        reg_wr(ert_pkg::ADDR_INT, 32'h0000_0101);
        reg_wr(ert_pkg::ADDR_CTRL, 32'h0000_0011);
        wait_irq(n);
        `CHK(n < 8, 1'b1)
        reg_rd(ert_pkg::ADDR_CTRL, d);
        `CHK(d, 32'h0000_0010)
        reg_rd(ert_pkg::ADDR_COUNT, d);
        `CHK(d, 32'h0000_0003)
        repeat (20) @(posedge mclk);
        reg_rd(ert_pkg::ADDR_COUNT, d);
        `CHK(d, 32'h0000_0003)
    endtask : t_modes

    task automatic t_stop_strobe;
        logic [31:0] c1;
        logic [31:0] c2;
        reg_wr(ert_pkg::ADDR_DIV, 32'h0000_0002);
        reg_wr(ert_pkg::ADDR_RELOAD, 32'h0000_0080);
        reg_wr(ert_pkg::ADDR_CTRL, 32'h0000_0002);
        reg_wr(ert_pkg::ADDR_CTRL, 32'h0000_0001);
        repeat (40) @(posedge mclk);
        reg_wr(ert_pkg::ADDR_CTRL, 32'h0000_0000);
        reg_rd(ert_pkg::ADDR_COUNT, c1);
        `CHK(c1 < 32'h0000_0080, 1'b1)
        repeat (40) @(posedge mclk);
        reg_rd(ert_pkg::ADDR_COUNT, c2);
        `CHK(c2, c1)
        reg_wr(ert_pkg::ADDR_CTRL, 32'h0000_0000);
        reg_rd(ert_pkg::ADDR_COUNT, c2);
        `CHK(c2, c1)
        reg_wr(ert_pkg::ADDR_CTRL, 32'h0000_0002);
        reg_rd(ert_pkg::ADDR_COUNT, c2);
        `CHK(c2, 32'h0000_0080)
        reg_rd(ert_pkg::ADDR_CTRL, c2);
        `CHK(c2, 32'h0000_0000)
        // The reserved code must freeze the count even while running.
        reg_wr(ert_pkg::ADDR_DIV, 32'h0000_000f);
        reg_wr(ert_pkg::ADDR_CTRL, 32'h0000_0001);
        repeat (100) @(posedge mclk);
        reg_rd(ert_pkg::ADDR_COUNT, c2);
        `CHK(c2, 32'h0000_0080)
        reg_wr(ert_pkg::ADDR_CTRL, 32'h0000_0000);
    endtask : t_stop_strobe

    task automatic t_irq_gate;
        logic [31:0] d;
        reg_wr(ert_pkg::ADDR_DIV, 32'h0000_0000);
        reg_wr(ert_pkg::ADDR_RELOAD, 32'h0000_0000);
        reg_wr(ert_pkg::ADDR_INT, 32'h0000_0001);
        reg_wr(ert_pkg::ADDR_CTRL, 32'h0000_0003);
        repeat (10) @(posedge mclk);
        reg_wr(ert_pkg::ADDR_CTRL, 32'h0000_0000);
        `CHK(irq, 1'b0)
        reg_rd(ert_pkg::ADDR_INT, d);
        `CHK(d, 32'h0000_0001)
        reg_wr(ert_pkg::ADDR_INT, 32'h0000_0000);
        reg_rd(ert_pkg::ADDR_INT, d);
        `CHK(d, 32'h0000_0001)
        reg_wr(ert_pkg::ADDR_INT, 32'h0000_0100);
        `CHK(irq, 1'b1)
        reg_wr(ert_pkg::ADDR_INT, 32'h0000_0101);
        `CHK(irq, 1'b0)
        reg_rd(ert_pkg::ADDR_INT, d);
        `CHK(d, 32'h0000_0100)
    endtask : t_irq_gate

    // ------------------------------------------------------------------
    // Verdict, clock, watchdog and main sequence.
    // ------------------------------------------------------------------

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    // Free-running 25 MHz clock.
    always #20 mclk = ~mclk;

    // A hang counts as a mismatch; the run needs about 33500 cycles.
    initial begin
        repeat (60000) @(posedge mclk);
        mismatches++;
        report_and_stop();
    end

    // Reset for 16 cycles, then every scenario in turn.
    initial begin
        mclk       = 1'b0;
        rst_b      = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 20'h00000;
        pwdata     = 32'h0000_0000;
        mismatches = 0;
        cmp_count  = 0;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        t_reset_access();
        t_divide();
        t_modes();
        t_stop_strobe();
        t_irq_gate();
        report_and_stop();
    end

endmodule : ert_timer_test
